//--- mcam_pkg.sv
// Package: register map, field positions and encodings for monitor config/mask
package mcam_pkg;
   // Register addresses on the internal register port
   localparam logic [7:0] ADDR_TACH_ONE_MIN_HI = 8'h55;
   localparam logic [7:0] ADDR_CONFIG_TWO = 8'h73;
   localparam logic [7:0] ADDR_ALERT_MASK_ONE = 8'h74;
   localparam logic [7:0] ADDR_CONFIG_FOUR = 8'h7D;
   localparam logic [7:0] ADDR_PWM1_CUR = 8'h30;
   localparam logic [7:0] ADDR_PWM2_CUR = 8'h31;
   localparam logic [7:0] ADDR_PWM3_CUR = 8'h32;
   // Reset values, and the value that duty reads return in shutdown
   localparam logic [7:0] RST_CONFIG_TWO = 8'h00;
   localparam logic [7:0] RST_ALERT_MASK = 8'h00;
   localparam logic [7:0] RST_TACH_ONE_MIN_HI = 8'hFF;
   localparam logic [7:0] RST_CONFIG_FOUR = 8'h00;
   localparam logic [7:0] OFF_DUTY_READ = 8'h00;
   // Configuration field positions
   localparam int BIT_BYPASS = 5;
   localparam int BIT_SINGLE = 6;
   localparam int BIT_SHUTDOWN = 7;
   localparam int CHSEL_LSB = 5;
   localparam int BYP_LSB = 4;
   localparam int MASK_STATUS_TWO = 7;
   // Channel codes in single-channel mode
   localparam logic [2:0] CH_2V5 = 3'h0;
   localparam logic [2:0] CH_CORE = 3'h1;
   localparam logic [2:0] CH_3V3 = 3'h2;
   localparam logic [2:0] CH_5V = 3'h3;
   localparam logic [2:0] CH_12V = 3'h4;
   localparam logic [2:0] CH_REMOTE1 = 3'h5;
   localparam logic [2:0] CH_LOCAL = 3'h6;
   localparam logic [2:0] CH_REMOTE2 = 3'h7;
   // Last channel code in the round-robin
   localparam logic [2:0] CH_LAST = 3'h7;
   // Converter mode
   typedef enum logic [0:0] {MODE_ROUND, MODE_SINGLE} mcam_mode_t;
endpackage

//--- mcam_monitor_config_and_alert_mask.sv
// Config bits, alert mask and channel sequencing for the hardware monitor
// Notes on behaviour
// - Global bypass removes four input attenuators
// - Per-channel bypass from config four bits
// - Single-channel bit stops round-robin conversion
// - Channel taken from tach min bits 7:5
// - Channel code decode, eight fixed inputs
// - Shutdown drives PWM to fan-off level
// - Shutdown makes current duty reads 0x00
// - Lock bit makes config register read-only
// - Mask bits 0-3 gate voltage alerts
// - Mask bits 4-6 gate temperature alerts
// - Mask bit 7 gates status two alerts
// - Mask register RW, resets to 0x00
// - Alert exists only when alert enable set
////////////////////////////////////////////////////////////////////////////////
module mcam_monitor_config_and_alert_mask (
   ref_clk,
   reset,
   clk_en,
   reg_wr,
   reg_rd,
   reg_addr,
   reg_wdata,
   reg_rdata,
   config_lock,
   alert_enable,
   pwm_polarity_invert,
   pwm_duty_in,
   pwm_raw,
   single_channel_convert_done,
   limit_flags,
   status_two_any,
   attenuator_bypass_bypass_n,
   single_channel_convert_channel,
   single_channel_convert,
   shutdown_request,
   pwm_out,
   alert_n_out,
   alert_oe_n
);
   input wire logic ref_clk;
   input wire logic reset;
   input wire logic clk_en;
   input wire logic reg_wr;
   input wire logic reg_rd;
   input wire logic [7:0] reg_addr;
   input wire logic [7:0] reg_wdata;
   output logic [7:0] reg_rdata;
   input wire logic config_lock;
   input wire logic alert_enable;
   input wire logic pwm_polarity_invert;
   input wire logic [23:0] pwm_duty_in;
   input wire logic [2:0] pwm_raw;
   input wire logic single_channel_convert_done;
   input wire logic [6:0] limit_flags;
   input wire logic status_two_any;
   output logic [3:0] attenuator_bypass_bypass_n;
   output logic [2:0] single_channel_convert_channel;
   output logic single_channel_convert;
   output logic shutdown_request;
   output logic [2:0] pwm_out;
   output logic alert_n_out;
   output logic alert_oe_n;

   // Hazards and limits worth knowing before touching this block:
   // the lock input is sampled with the write strobe, so a write in the
   // same cycle as the lock rising is still refused.
   // The channel field lives in the tach minimum register and is read
   // live in single-channel mode, so rewriting that register moves the
   // converter at once; hosts load it before setting the mode bit.
   // Every output is registered, which costs one cycle of latency but
   // keeps glitches off the fan and alert pins.

   logic [2:0] cfg_upper_r;
   logic [7:0] mask_r;
   logic [7:0] tach_hi_r;
   logic [7:0] cfg_four_r;
   logic [2:0] chan_r;
   logic [3:0] attenuator_bypass_r;
   logic [2:0] pwm_r;
   logic alert_r;
   logic [7:0] rdata_r;
   logic [2:0] chan_nxt;
   logic [7:0] rdata_nxt;
   logic [3:0] attenuator_bypass_nxt;
   logic [2:0] pwm_nxt;
   logic alert_nxt;
   logic [2:0] sel_chan;
   logic [7:0] cfg_two_read;
   logic wr_cfg;
   logic wr_mask;
   logic wr_tach;
   logic wr_four;
   logic fans_off;
   logic [7:0] alert_src;
   mcam_pkg::mcam_mode_t mode;

   // Duty read helper: forced to zero while fans are off
   function automatic logic [7:0] duty_read(input logic [7:0] d,
                                            input logic off);
      duty_read = off ? mcam_pkg::OFF_DUTY_READ : d;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Write decode
   assign wr_cfg = reg_wr && reg_addr == mcam_pkg::ADDR_CONFIG_TWO
                   && !config_lock;
   assign wr_mask = reg_wr && reg_addr == mcam_pkg::ADDR_ALERT_MASK_ONE;
   assign wr_tach = reg_wr && reg_addr == mcam_pkg::ADDR_TACH_ONE_MIN_HI;
   assign wr_four = reg_wr && reg_addr == mcam_pkg::ADDR_CONFIG_FOUR
                    && !config_lock;
   assign fans_off = cfg_upper_r[2];
   assign mode = cfg_upper_r[1] ? mcam_pkg::MODE_SINGLE
                                : mcam_pkg::MODE_ROUND;
   // Channel field; host must load it before the mode bit
   assign sel_chan = tach_hi_r[mcam_pkg::CHSEL_LSB +: 3];
   assign cfg_two_read = {cfg_upper_r, 5'h00};

   // Registers; mask is plain RW with all sources unmasked at reset
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cfg_upper_r <= 3'h0;
         mask_r <= mcam_pkg::RST_ALERT_MASK;
         tach_hi_r <= mcam_pkg::RST_TACH_ONE_MIN_HI;
         cfg_four_r <= mcam_pkg::RST_CONFIG_FOUR;
      end else if (clk_en) begin
         if (wr_cfg) begin
            cfg_upper_r <= reg_wdata[mcam_pkg::BIT_BYPASS +: 3];
         end
         if (wr_mask) begin
            mask_r <= reg_wdata;
         end
         if (wr_tach) begin
            tach_hi_r <= reg_wdata;
         end
         if (wr_four) begin
            cfg_four_r <= reg_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel sequencing: round-robin or pinned to the selected input
   always_comb begin
      chan_nxt = chan_r;
      case (mode)
         mcam_pkg::MODE_SINGLE: chan_nxt = sel_chan;
         mcam_pkg::MODE_ROUND: begin
            if (single_channel_convert_done) begin
               chan_nxt = (chan_r == mcam_pkg::CH_LAST) ? mcam_pkg::CH_2V5
                          : 3'(chan_r + 3'h1);
            end
         end
         default: chan_nxt = mcam_pkg::CH_2V5;
      endcase
   end

   // Bypass: bit order 2.5V, core, 5V, 12V; global OR per-channel
   assign attenuator_bypass_nxt = ~({4{cfg_upper_r[0]}}
                       | cfg_four_r[mcam_pkg::BYP_LSB +: 4]);

   // Fan-off level is low, or high when inverted
   assign pwm_nxt = fans_off ? {3{pwm_polarity_invert}} : pwm_raw;

   // Alert sources; status flags themselves are never touched here
   // Masking only gates the pin, so a masked limit still shows in status
   assign alert_src = {status_two_any, limit_flags}
                      & ~mask_r;
   assign alert_nxt = alert_enable && (|alert_src);

   // Read mux, registered; unmapped addresses read zero
   always_comb begin
      case (reg_addr)
         mcam_pkg::ADDR_CONFIG_TWO: rdata_nxt = cfg_two_read;
         mcam_pkg::ADDR_ALERT_MASK_ONE: rdata_nxt = mask_r;
         mcam_pkg::ADDR_TACH_ONE_MIN_HI: rdata_nxt = tach_hi_r;
         mcam_pkg::ADDR_CONFIG_FOUR: rdata_nxt = cfg_four_r;
         mcam_pkg::ADDR_PWM1_CUR:
            rdata_nxt = duty_read(pwm_duty_in[7:0], fans_off);
         mcam_pkg::ADDR_PWM2_CUR:
            rdata_nxt = duty_read(pwm_duty_in[15:8], fans_off);
         mcam_pkg::ADDR_PWM3_CUR:
            rdata_nxt = duty_read(pwm_duty_in[23:16], fans_off);
         default: rdata_nxt = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output flops so every output is registered
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         chan_r <= mcam_pkg::CH_2V5;
         attenuator_bypass_r <= 4'hF;
         pwm_r <= 3'h0;
         alert_r <= 1'b0;
         rdata_r <= 8'h00;
      end else if (clk_en) begin
         chan_r <= chan_nxt;
         attenuator_bypass_r <= attenuator_bypass_nxt;
         pwm_r <= pwm_nxt;
         alert_r <= alert_nxt;
         if (reg_rd) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   assign reg_rdata = rdata_r;
   assign single_channel_convert_channel = chan_r;
   assign attenuator_bypass_bypass_n = attenuator_bypass_r;
   assign single_channel_convert = cfg_upper_r[1];
   assign shutdown_request = cfg_upper_r[2];
   assign pwm_out = pwm_r;
   // Open-drain alert: enable low pulls the pin low while alerting
   // The data side is fixed low; only the enable ever moves, so the
   // pin can never be driven high against other devices on the line
   assign alert_n_out = 1'b0;
   assign alert_oe_n = ~alert_r;
endmodule

//--- mcam_chk_assertions.sv
// Checker: port-level properties of the config and alert mask block
module mcam_chk (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic config_lock,
   input wire logic alert_enable,
   input wire logic pwm_polarity_invert,
   input wire logic [6:0] limit_flags,
   input wire logic status_two_any,
   input wire logic [2:0] single_channel_convert_channel,
   input wire logic single_channel_convert,
   input wire logic shutdown_request,
   input wire logic [2:0] pwm_out,
   input wire logic alert_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mask_r;
   logic [2:0] chan_r;
   logic [7:0] live;
   // Unmasked sources; the alert must follow these one edge later
   assign live = {status_two_any, limit_flags} & ~mask_r;
   // Shadows of the mask and the channel field, kept from the writes
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         mask_r <= 8'h00;
         chan_r <= 3'h7;
      end else if (reg_wr && reg_addr == 8'h74) begin
         mask_r <= reg_wdata;
      end else if (reg_wr && reg_addr == 8'h55) begin
         chan_r <= reg_wdata[7:5];
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   sequence take_rd(a);
      reg_rd && reg_addr == a;
   endsequence
   sequence locked_wr;
      config_lock && reg_wr && reg_addr == 8'h73;
   endsequence
   property duty_zero(a);
      shutdown_request ##0 take_rd(a) |=> reg_rdata == 8'h00;
   endproperty
   ////////////////////////////////////////////////////////////////////////////
   alert_gate_a: assert property (
      alert_enable |=> alert_oe_n == !(|$past(live))) else $error("alert");
   alert_off_a: assert property (!alert_enable |=> alert_oe_n)
      else $error("alert while off");
   fan_off_a: assert property (
      shutdown_request && $past(shutdown_request) |->
      pwm_out == {3{$past(pwm_polarity_invert)}}) else $error("fan on");
   duty_lo_a: assert property (duty_zero(8'h30)) else $error("duty");
   duty_hi_a: assert property (duty_zero(8'h32)) else $error("duty");
   mask_rd_a: assert property (
      take_rd(8'h74) |=> reg_rdata == $past(mask_r))
      else $error("mask readback");
   lock_hold_a: assert property (
      locked_wr |-> ##2 {single_channel_convert, shutdown_request} ==
      $past({single_channel_convert, shutdown_request}, 2)) else $error("lock");
   chan_sel_a: assert property (
      (single_channel_convert && $stable(chan_r)) [*3] |->
      single_channel_convert_channel == chan_r) else $error("channel");
endmodule
bind mcam_monitor_config_and_alert_mask mcam_chk u_chk (.ref_clk, .reset,
   .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .config_lock,
   .alert_enable, .pwm_polarity_invert, .limit_flags, .status_two_any,
   .single_channel_convert_channel, .single_channel_convert, .shutdown_request, .pwm_out,
   .alert_oe_n);

//--- mcam_host_model.sv
// Host side: pull-up on the shared open-drain alert line
module mcam_host_model (
   input wire logic alert_n_out,
   input wire logic alert_oe_n,
   output logic alert_line
);
   timeunit 1ns;
   timeprecision 1ps;
   // A released line rises to the pull-up, never keeps the last level
   assign alert_line = alert_oe_n ? 1'b1 : alert_n_out;
endmodule

//--- mcam_monitor_config_and_alert_mask_tb.sv
// Testbench: registers, alert masking, channel select, shutdown and lock
module mcam_monitor_config_and_alert_mask_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, reset, reg_wr, reg_rd, config_lock, alert_enable, pol_inv;
   logic single_channel_convert_done, st2, single, shut, alert_n_out, alert_oe_n, alert_line;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [23:0] duty;
   logic [6:0] lim;
   logic [3:0] attenuator_bypass_n;
   logic [2:0] chan, pwm_out, raw;
   int bad_count = 0, checks_done = 0, seed = 24;
   int m_mask = 0, m_cfg = 0, m_tach = 255, m_four = 0;
   mcam_monitor_config_and_alert_mask u_dut (.ref_clk, .reset, .clk_en(1'b1),
      .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .config_lock,
      .alert_enable, .pwm_polarity_invert(pol_inv), .pwm_duty_in(duty),
      .pwm_raw(raw), .single_channel_convert_done, .limit_flags(lim), .status_two_any(st2),
      .attenuator_bypass_bypass_n(attenuator_bypass_n), .single_channel_convert_channel(chan), .pwm_out,
      .single_channel_convert(single), .shutdown_request(shut),
      .alert_n_out, .alert_oe_n);
   mcam_host_model u_host (.alert_n_out, .alert_oe_n, .alert_line);
   initial begin
      ref_clk = 0;
      forever #10 ref_clk = ~ref_clk;
   end
   // Fan waveforms and conversion pulses keep moving in every test
   always @(negedge ref_clk) {single_channel_convert_done, raw} = 4'($random(seed));
   task automatic chk(string n, logic [7:0] e, logic [7:0] s);
      checks_done++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   // Register view of the model; duty reads drop to zero in shutdown
   function automatic logic [7:0] exp_rd(logic [7:0] a);
      case (a)
         8'h74: return 8'(m_mask);
         8'h73: return 8'(m_cfg);
         8'h55: return 8'(m_tach);
         8'h7D: return 8'(m_four);
         8'h30, 8'h31, 8'h32:
            return m_cfg[7] ? 8'h00 : duty[8*(a-8'h30) +: 8];
         default: return 8'h00;
      endcase
   endfunction
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      @(negedge ref_clk) reg_wr = 0;
      if (a == 8'h74) m_mask = d;
      if (a == 8'h55) m_tach = d;
      if (!config_lock && a == 8'h73) m_cfg = d & 8'hE0;
      if (!config_lock && a == 8'h7D) m_four = d;
      repeat (2) @(negedge ref_clk);
   endtask
   task automatic rd(logic [7:0] a);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1;
      @(negedge ref_clk) reg_rd = 0;
      chk("reg_rdata", exp_rd(a), reg_rdata);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {reset, reg_wr, reg_rd, config_lock, alert_enable, pol_inv, st2} = 7'h40;
      {reg_addr, reg_wdata, duty, lim} = '0;
      repeat (5) @(negedge ref_clk);
      reset = 0;
      rd(8'h74);
      rd(8'h55);
      repeat (24) begin
         wr(8'h74, 8'($random(seed)));
         rd(8'h74);
         {alert_enable, st2, lim, pol_inv} = 10'($random(seed));
         duty = 24'($random(seed));
         repeat (2) @(negedge ref_clk);
         chk("alert_line", !(alert_enable && |({st2, lim} & ~m_mask[7:0])),
            alert_line);
      end
      for (int c = 0; c < 8; c++) begin
         wr(8'h55, 8'(c << 5));
         wr(8'h73, 8'h40);
         chk("single_channel_convert_channel", 8'(c), chan);
         chk("single_channel_convert", 8'h01, single);
      end
      wr(8'h73, 8'h20);
      chk("attenuator_bypass_bypass_n", 8'h00, attenuator_bypass_n);
      wr(8'h73, 8'h00);
      wr(8'h7D, 8'h50);
      chk("attenuator_bypass_bypass_n", 8'h0A, attenuator_bypass_n);
      rd(8'h7D);
      for (int a = 8'h30; a < 8'h33; a++) rd(8'(a));
      wr(8'h73, 8'h80);
      chk("shutdown_request", 8'h01, shut);
      for (int i = 0; i < 2; i++) begin
         pol_inv = i[0];
         repeat (2) @(negedge ref_clk);
         chk("pwm_out", {5'h00, {3{pol_inv}}}, pwm_out);
      end
      for (int a = 8'h30; a < 8'h34; a++) rd(8'(a));
      config_lock = 1;
      wr(8'h73, 8'h00);
      rd(8'h73);
      wr(8'h7D, 8'h00);
      rd(8'h7D);
      chk("attenuator_bypass_bypass_n", 8'h0A, attenuator_bypass_n);
      report_and_stop();
   end
   // Cut a hang short well beyond the expected run time
   initial begin
      #200000;
      bad_count++;
      report_and_stop();
   end
endmodule
